//--- ipc_ctrl.sv
// priority interrupt controller: request capture, arbitration, vectoring, pc stack
// assumes core control bits arrive on this clock; external pins are asynchronous
`timescale 1ns/100ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// How it works
// - equal level: fixed thirteen-source polling order
// - power management alone on top level
// - deep-sleep wake makes external request pending
// - sleep events leave external flags untouched
// - temperature and serial requests latched until vectored
// - serial status clear never cancels pending request
// - rtc request follows alarm or interval flag
// - rtc routine entry leaves request alone
// - flag-driven sources not cleared on entry
// - external flag cleared only in edge mode
// - low level keeps external request asserted
// - grant pushes pc then loads vector
// - return pops saved pc
// - fixed vector address per source
// - one instruction between return or access and vector
// - at least 3.25 instruction cycles latency
// - worst high latency within 16.25 cycles
// - only pc saved on stack
// - temperature request has no visible flag
// - higher level preempts, never same level
// - global enable gates every source
module ipc_ctrl #(
    parameter int unsigned QTR_CYC = 2
) (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,
    // peripheral request flags
    input  wire logic        power_mgmt_flag_i,
    input  wire logic        rtc_alarm_flag_i,
    input  wire logic        rtc_interval_flag_i,
    input  wire logic        energy_meter_flag_i,
    input  wire logic        watchdog_timeout_flag_i,
    input  wire logic        temperature_irq_i,
    input  wire logic        timer0_overflow_flag_i,
    input  wire logic        timer1_overflow_flag_i,
    input  wire logic        serial_periph_irq_i,
    input  wire logic        uart_rx_tx_irq_i,
    input  wire logic        timer2_irq_i,
    input  wire logic        uart_second_rx_tx_irq_i,
    // external pins and wake-up
    input  wire logic        ext0_pin_b_i,
    input  wire logic        ext1_pin_b_i,
    input  wire logic [1:0]  ext_edge_select_i,
    input  wire logic        deep_sleep_mode_i,
    input  wire logic        ext0_wake_i,
    input  wire logic        ext1_wake_i,
    // configuration
    input  wire logic        global_irq_enable_i,
    input  wire logic [12:0] irq_enable_i,
    input  wire logic [12:0] priority_select_i,
    // core handshake
    input  wire logic [15:0] pc_i,
    input  wire logic        reti_i,
    input  wire logic        enable_prio_access_i,
    input  wire logic        instr_done_i,
    // vector and stack
    output logic             vec_valid_o,
    output logic [15:0]      vec_addr_o,
    output logic             push_valid_o,
    output logic [15:0]      push_pc_o,
    output logic             resume_valid_o,
    output logic [15:0]      resume_pc_o,
    output logic [12:0]      src_ack_o,
    output logic [1:0]       cur_level_o,
    // timer control flags
    output logic             ext0_irq_flag_o,
    output logic             ext1_irq_flag_o
);
    import ipc_pkg::*;

    typedef struct packed {
        logic [1:0]                  ext0_sync;
        logic [1:0]                  ext1_sync;
        logic                        ext0_prev;
        logic                        ext1_prev;
        logic                        ext0_flag;
        logic                        ext1_flag;
        logic                        ext0_wake;
        logic                        ext1_wake;
        logic                        temp_pend;
        logic                        serial_pend;
        logic                        hold;
        ipc_state_t                  st;
        logic [6:0]                  cnt;
        logic [3:0]                  idx;
        logic [1:0]                  lvl;
        logic [1:0]                  depth;
        logic [STACK_DEPTH-1:0][15:0] pc_stk;
        logic [STACK_DEPTH-1:0][1:0]  lvl_stk;
        logic                        vec_valid;
        logic [15:0]                 vec_addr;
        logic                        push_valid;
        logic [15:0]                 push_pc;
        logic                        resume_valid;
        logic [15:0]                 resume_pc;
        logic [12:0]                 ack;
        logic [1:0]                  lvl_out;
    } ipc_ctrl_st_t;

    ipc_ctrl_st_t st_ff;
    ipc_ctrl_st_t nxt_st;

    logic        qtr;
    logic        instr;
    logic [12:0] req;
    logic [12:0] elig;
    logic        win_vld;
    logic [3:0]  win_idx;
    logic [1:0]  win_lvl;
    logic [1:0]  cur_lvl;
    logic        ext0_low;
    logic        ext1_low;
    logic        ext0_fall;
    logic        ext1_fall;
    logic        vec_now;
    logic [15:0] top_pc;

    ipc_tick_gen #(.QTR_CYC(QTR_CYC)) u_tick (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .qtr_o   (qtr),
        .instr_o (instr)
    );

    //////////////////////////////////////////////////////////////////////////
    // request formation

    assign ext0_low  = ~st_ff.ext0_sync[1];
    assign ext1_low  = ~st_ff.ext1_sync[1];
    assign ext0_fall = st_ff.ext0_prev & ~st_ff.ext0_sync[1];
    assign ext1_fall = st_ff.ext1_prev & ~st_ff.ext1_sync[1];
    assign cur_lvl   = st_ff.lvl_out;
    assign top_pc    = (st_ff.depth == 2'h0) ? RST_PC : st_ff.pc_stk[st_ff.depth - 2'h1];

    always_comb begin
        req             = '0;
        req[SRC_PWR]    = power_mgmt_flag_i;
        req[SRC_RTC]    = rtc_alarm_flag_i | rtc_interval_flag_i;
        req[SRC_ENERGY] = energy_meter_flag_i;
        req[SRC_WDOG]   = watchdog_timeout_flag_i;
        req[SRC_TEMP]   = st_ff.temp_pend;
        req[SRC_EXT0]   = st_ff.ext0_flag | st_ff.ext0_wake;
        req[SRC_TMR0]   = timer0_overflow_flag_i;
        req[SRC_EXT1]   = st_ff.ext1_flag | st_ff.ext1_wake;
        req[SRC_TMR1]   = timer1_overflow_flag_i;
        req[SRC_SERIAL] = st_ff.serial_pend;
        req[SRC_UART]   = uart_rx_tx_irq_i;
        req[SRC_TMR2]   = timer2_irq_i;
        req[SRC_UART2]  = uart_second_rx_tx_irq_i;
        elig            = req & irq_enable_i & {13{global_irq_enable_i}};
    end

    ipc_arbiter u_arb (
        .elig_i      (elig),
        .prio_high_i (priority_select_i),
        .cur_lvl_i   (cur_lvl),
        .win_vld_o   (win_vld),
        .win_idx_o   (win_idx),
        .win_lvl_o   (win_lvl)
    );

    // vector only if the captured request is still eligible; an rtc flag cleared meanwhile cancels it
    assign vec_now = (st_ff.st == IPC_WAIT) && qtr && (st_ff.cnt == 7'h01) && elig[st_ff.idx];

    //////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nxt_st              = st_ff;
        nxt_st.vec_valid    = 1'b0;
        nxt_st.push_valid   = 1'b0;
        nxt_st.resume_valid = 1'b0;
        nxt_st.ack          = '0;
        nxt_st.ext0_sync    = {st_ff.ext0_sync[0], ext0_pin_b_i};
        nxt_st.ext1_sync    = {st_ff.ext1_sync[0], ext1_pin_b_i};
        nxt_st.ext0_prev    = st_ff.ext0_sync[1];
        nxt_st.ext1_prev    = st_ff.ext1_sync[1];

        // vector clears: external wake latches, edge-mode external flags, temperature and serial sources
        if (vec_now) begin
            if (st_ff.idx == SRC_EXT0) begin
                nxt_st.ext0_wake = 1'b0;
                if (ext_edge_select_i[0])
                    nxt_st.ext0_flag = 1'b0;
            end
            if (st_ff.idx == SRC_EXT1) begin
                nxt_st.ext1_wake = 1'b0;
                if (ext_edge_select_i[1])
                    nxt_st.ext1_flag = 1'b0;
            end
            if (st_ff.idx == SRC_TEMP)
                nxt_st.temp_pend = 1'b0;
            if (st_ff.idx == SRC_SERIAL)
                nxt_st.serial_pend = 1'b0;
        end

        // sets come after clears so a same-cycle event survives
        if (!deep_sleep_mode_i) begin
            if (!ext_edge_select_i[0])
                nxt_st.ext0_flag = ext0_low;
            else if (ext0_fall)
                nxt_st.ext0_flag = 1'b1;
            if (!ext_edge_select_i[1])
                nxt_st.ext1_flag = ext1_low;
            else if (ext1_fall)
                nxt_st.ext1_flag = 1'b1;
        end else begin
            if (ext0_wake_i)
                nxt_st.ext0_wake = 1'b1;
            if (ext1_wake_i)
                nxt_st.ext1_wake = 1'b1;
        end
        if (temperature_irq_i)
            nxt_st.temp_pend = 1'b1;
        if (serial_periph_irq_i)
            nxt_st.serial_pend = 1'b1;

        // hold-off until the next instruction completes
        if (instr_done_i)
            nxt_st.hold = 1'b0;
        if (reti_i || enable_prio_access_i)
            nxt_st.hold = 1'b1;

        unique case (st_ff.st)
            IPC_IDLE: begin
                if (instr && win_vld && !st_ff.hold) begin
                    nxt_st.st  = IPC_WAIT;
                    nxt_st.idx = win_idx;
                    nxt_st.lvl = win_lvl;
                    nxt_st.cnt = LAT_MIN_Q;
                end
            end
            IPC_WAIT: begin
                if (qtr) begin
                    nxt_st.cnt = st_ff.cnt - 7'h01;
                    if (st_ff.cnt == 7'h01)
                        nxt_st.st = IPC_IDLE;
                end
                if (vec_now) begin
                    nxt_st.push_valid              = 1'b1;
                    nxt_st.push_pc                 = pc_i;
                    nxt_st.pc_stk[st_ff.depth]     = pc_i;
                    nxt_st.lvl_stk[st_ff.depth]    = st_ff.lvl;
                    nxt_st.depth                   = st_ff.depth + 2'h1;
                    nxt_st.vec_valid               = 1'b1;
                    nxt_st.vec_addr                = VEC_TABLE[st_ff.idx];
                    nxt_st.ack[st_ff.idx]          = 1'b1;
                end
            end
        endcase

        // a return pops the saved pc and drops back one level
        if (reti_i && st_ff.depth != 2'h0 && !vec_now) begin
            nxt_st.resume_valid = 1'b1;
            nxt_st.resume_pc    = top_pc;
            nxt_st.depth        = st_ff.depth - 2'h1;
        end
        // level in service kept in a flop so the output needs no mux after it
        nxt_st.lvl_out = (nxt_st.depth == 2'h0) ? LVL_NONE : nxt_st.lvl_stk[nxt_st.depth - 2'h1];
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_ff           <= '0;
            st_ff.ext0_sync <= 2'h3;
            st_ff.ext1_sync <= 2'h3;
            st_ff.ext0_prev <= 1'b1;
            st_ff.ext1_prev <= 1'b1;
            st_ff.st        <= IPC_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign vec_valid_o     = st_ff.vec_valid;
    assign vec_addr_o      = st_ff.vec_addr;
    assign push_valid_o    = st_ff.push_valid;
    assign push_pc_o       = st_ff.push_pc;
    assign resume_valid_o  = st_ff.resume_valid;
    assign resume_pc_o     = st_ff.resume_pc;
    assign src_ack_o       = st_ff.ack;
    assign cur_level_o     = st_ff.lvl_out;
    assign ext0_irq_flag_o = st_ff.ext0_flag;
    assign ext1_irq_flag_o = st_ff.ext1_flag;

    //////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    localparam int LAT_MAX_CYC = int'(LAT_MAX_Q) * int'(QTR_CYC);

    a_psm_top_level: assert property (st_ff.st == IPC_WAIT && st_ff.idx == SRC_PWR |-> st_ff.lvl == LVL_PWR)
        else $error("power management not at top level");
    a_no_same_preempt: assert property ($rose(st_ff.st == IPC_WAIT) |-> st_ff.lvl > $past(cur_lvl))
        else $error("grant at or below level in service");
    a_global_gate: assert property (!global_irq_enable_i && st_ff.st == IPC_IDLE |=> st_ff.st == IPC_IDLE)
        else $error("grant while globally disabled");
    a_hold_blocks: assert property (st_ff.st == IPC_IDLE && st_ff.hold |=> st_ff.st == IPC_IDLE)
        else $error("vector sequence started during hold-off");
    a_push_with_vec: assert property (vec_valid_o |-> push_valid_o && push_pc_o == $past(pc_i))
        else $error("vector without pc push");
    a_pop_top: assert property (reti_i && st_ff.depth != 2'h0 && !vec_now |=> resume_valid_o && resume_pc_o == $past(top_pc))
        else $error("return did not pop saved pc");
    a_temp_latched: assert property (st_ff.temp_pend && !(vec_now && st_ff.idx == SRC_TEMP) |=> st_ff.temp_pend)
        else $error("temperature request lost");
    a_min_latency: assert property ($rose(st_ff.st == IPC_WAIT) |-> st_ff.cnt == LAT_MIN_Q ##1 !vec_valid_o [*3])
        else $error("latency count not loaded");
    a_wait_bound: assert property (st_ff.st == IPC_WAIT |-> ##[0:LAT_MAX_CYC] st_ff.st == IPC_IDLE)
        else $error("wait beyond worst-case latency");
    a_sleep_flags: assert property (deep_sleep_mode_i && st_ff.st == IPC_IDLE |=> $stable(st_ff.ext0_flag))
        else $error("external flag changed in deep sleep");
    a_vec_addr: assert property (vec_valid_o && src_ack_o[SRC_EXT0] |-> vec_addr_o == 16'h0003)
        else $error("wrong external 0 vector");

endmodule // ipc_ctrl
`default_nettype wire

//--- ipc_pkg.sv
// constants, types and helper functions of the priority interrupt controller
// assumes one 40 MHz clock; source index equals the polling position within a level
`default_nettype none
package ipc_pkg;

    localparam int unsigned NUM_SRC        = 13;
    localparam int unsigned STACK_DEPTH    = 3;
    localparam int unsigned QTR_PER_INSTR  = 4;

    // latency figures in quarters of an instruction cycle (3.25 and 16.25 cycles)
    localparam logic [6:0]  LAT_MIN_Q      = 7'h0d;
    localparam logic [6:0]  LAT_MAX_Q      = 7'h41;

    // source indices in polling order, 0 polled first
    localparam logic [3:0]  SRC_PWR        = 4'h0;
    localparam logic [3:0]  SRC_RTC        = 4'h1;
    localparam logic [3:0]  SRC_ENERGY     = 4'h2;
    localparam logic [3:0]  SRC_WDOG       = 4'h3;
    localparam logic [3:0]  SRC_TEMP       = 4'h4;
    localparam logic [3:0]  SRC_EXT0       = 4'h5;
    localparam logic [3:0]  SRC_TMR0       = 4'h6;
    localparam logic [3:0]  SRC_EXT1       = 4'h7;
    localparam logic [3:0]  SRC_TMR1       = 4'h8;
    localparam logic [3:0]  SRC_SERIAL     = 4'h9;
    localparam logic [3:0]  SRC_UART       = 4'ha;
    localparam logic [3:0]  SRC_TMR2       = 4'hb;
    localparam logic [3:0]  SRC_UART2      = 4'hc;

    // priority levels; none means no routine in service
    localparam logic [1:0]  LVL_NONE       = 2'h0;
    localparam logic [1:0]  LVL_LOW        = 2'h1;
    localparam logic [1:0]  LVL_HIGH       = 2'h2;
    localparam logic [1:0]  LVL_PWR        = 2'h3;

    // vector addresses indexed by source
    localparam logic [15:0] VEC_TABLE [NUM_SRC] = '{
        16'h0043, 16'h0053, 16'h004b, 16'h005b, 16'h0033, 16'h0003, 16'h000b,
        16'h0013, 16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0063};

    localparam logic [15:0] RST_PC         = 16'h0000;

    typedef enum logic {IPC_IDLE, IPC_WAIT} ipc_state_t;

    // level of one source: power management sits alone above both user levels
    function automatic logic [1:0] ipc_src_lvl(input logic [3:0] idx, input logic hi);
        if (idx == SRC_PWR)
            return LVL_PWR;
        return hi ? LVL_HIGH : LVL_LOW;
    endfunction

endpackage
`default_nettype wire

//--- ipc_tick_gen.sv
// quarter-instruction and instruction-cycle enable pulses
// assumes the core instruction cycle is a whole number of clocks split into four quarters
`timescale 1ns/100ps
`default_nettype none
module ipc_tick_gen #(
    parameter int unsigned QTR_CYC = 2
) (
    // clock and reset
    input  wire logic clock_i,
    input  wire logic rst_b_i,
    // enables
    output logic      qtr_o,
    output logic      instr_o
);
    import ipc_pkg::*;

    typedef struct packed {
        logic [7:0] div;
        logic [1:0] qtr;
        logic       qtr_p;
        logic       instr_p;
    } ipc_tick_st_t;

    ipc_tick_st_t st_ff;
    ipc_tick_st_t nxt_st;

    always_comb begin
        nxt_st         = st_ff;
        nxt_st.qtr_p   = 1'b0;
        nxt_st.instr_p = 1'b0;
        if (st_ff.div == 8'(QTR_CYC - 1)) begin
            nxt_st.div   = 8'h00;
            nxt_st.qtr_p = 1'b1;
            nxt_st.qtr   = st_ff.qtr + 2'h1;
            if (st_ff.qtr == 2'(QTR_PER_INSTR - 1)) begin
                nxt_st.instr_p = 1'b1;
            end
        end else begin
            nxt_st.div = st_ff.div + 8'h01;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign qtr_o   = st_ff.qtr_p;
    assign instr_o = st_ff.instr_p;

endmodule // ipc_tick_gen
`default_nettype wire

//--- ipc_arbiter.sv
// picks the winning source: highest level first, polling order within a level
// assumes eligible requests already gated by enables; purely combinational
`timescale 1ns/100ps
`default_nettype none
module ipc_arbiter (
    // requests
    input  wire logic [12:0] elig_i,
    input  wire logic [12:0] prio_high_i,
    input  wire logic [1:0]  cur_lvl_i,
    // winner
    output logic             win_vld_o,
    output logic [3:0]       win_idx_o,
    output logic [1:0]       win_lvl_o
);
    import ipc_pkg::*;

    logic [1:0] lvl;

    always_comb begin
        win_vld_o = 1'b0;
        win_idx_o = 4'h0;
        win_lvl_o = LVL_NONE;
        lvl       = LVL_NONE;
        // scan from the last polled source so the first polled at the top level wins
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            lvl = ipc_src_lvl(4'(i), prio_high_i[i]);
            if (elig_i[i] && lvl >= win_lvl_o) begin
                win_idx_o = 4'(i);
                win_lvl_o = lvl;
            end
        end
        // only a strictly higher level preempts the routine in service
        win_vld_o = (|elig_i) && (win_lvl_o > cur_lvl_i);
    end

endmodule // ipc_arbiter
`default_nettype wire

//--- ipc_core_model.sv
// behavioural core: completes an instruction every four clocks, follows vectors and returns
// assumes the controller's outputs are registered on the same clock
`timescale 1ns/100ps
`default_nettype none
module ipc_core_model (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,
    // controller side
    input  wire logic        vec_valid_i,
    input  wire logic [15:0] vec_addr_i,
    input  wire logic        resume_valid_i,
    input  wire logic [15:0] resume_pc_i,
    input  wire logic        reti_req_i,
    output logic             reti_o,
    output logic             instr_done_o,
    output logic [15:0]      pc_o
);
    logic [1:0] phase;
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase        <= 2'h0;
            pc_o         <= 16'h0100;
            reti_o       <= 1'b0;
            instr_done_o <= 1'b0;
        end else begin
            phase        <= phase + 2'h1;
            instr_done_o <= (phase == 2'h3);
            reti_o       <= reti_req_i;
            // only the pc travels; no other context is handed over
            if (vec_valid_i)
                pc_o <= vec_addr_i;
            else if (resume_valid_i)
                pc_o <= resume_pc_i;
            else if (phase == 2'h3)
                pc_o <= pc_o + 16'h0002;
        end
    end
endmodule // ipc_core_model
`default_nettype wire

//--- tb_priority_interrupt_controller.sv
// self-checking bench: polling order, levels, clearing rules, nesting and returns
// assumes the core model supplies pc, instruction completions and returns
`timescale 1ns/100ps
`default_nettype none
module tb_priority_interrupt_controller;
    import ipc_pkg::*;
    logic        clock_i, rst_b_i, gen, sleep, w0, alarm, reti_req, acc;
    logic [12:0] req, en, hi;
    logic [1:0]  edge_sel, lvl;
    logic [15:0] pc, vec_a, push_pc, res_pc, got, ppc, pc_at;
    logic [15:0] pushed [3];
    logic        reti, idone, vec_v, push_v, res_v, f0;
    int          err_total, comparisons, n;
    int          cyc = 0;
    int          keep_src [7] = '{0, 1, 2, 10, 11, 12, 5};
    ipc_ctrl #(.QTR_CYC(1)) dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .power_mgmt_flag_i(req[0]), .rtc_alarm_flag_i(alarm), .rtc_interval_flag_i(req[1]),
        .energy_meter_flag_i(req[2]), .watchdog_timeout_flag_i(req[3]), .temperature_irq_i(req[4]),
        .timer0_overflow_flag_i(req[6]), .timer1_overflow_flag_i(req[8]), .serial_periph_irq_i(req[9]),
        .uart_rx_tx_irq_i(req[10]), .timer2_irq_i(req[11]), .uart_second_rx_tx_irq_i(req[12]),
        .ext0_pin_b_i(~req[5]), .ext1_pin_b_i(~req[7]), .ext_edge_select_i(edge_sel),
        .deep_sleep_mode_i(sleep), .ext0_wake_i(w0), .ext1_wake_i(w0),
        .global_irq_enable_i(gen), .irq_enable_i(en), .priority_select_i(hi), .pc_i(pc),
        .reti_i(reti), .enable_prio_access_i(acc), .instr_done_i(idone), .vec_valid_o(vec_v),
        .vec_addr_o(vec_a), .push_valid_o(push_v), .push_pc_o(push_pc), .resume_valid_o(res_v),
        .resume_pc_o(res_pc), .src_ack_o(), .cur_level_o(lvl), .ext0_irq_flag_o(f0),
        .ext1_irq_flag_o());
    ipc_core_model core (.clock_i(clock_i), .rst_b_i(rst_b_i), .vec_valid_i(vec_v), .vec_addr_i(vec_a),
        .resume_valid_i(res_v), .resume_pc_i(res_pc), .reti_req_i(reti_req), .reti_o(reti),
        .instr_done_o(idone), .pc_o(pc));
    //////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // got reads ffff when no vector came, so a stale address never passes
    task automatic wait_vec(input int lim);
        n = -1;
        got = 16'hffff;
        ppc = pc;
        for (int i = 1; i <= lim && n < 0; i++) begin
            @(negedge clock_i);
            if (vec_v === 1'b1) begin
                n = i;
                got = vec_a;
                pc_at = ppc;
            end
            ppc = pc;
        end
    endtask
    task automatic do_reset(input logic g = 1'b1);
        @(posedge clock_i);
        {req, en, hi, gen, sleep, w0, alarm, reti_req, edge_sel, acc} <= '0;
        rst_b_i <= 1'b0;
        repeat (6) @(posedge clock_i);
        rst_b_i <= 1'b1;
        @(posedge clock_i);
        gen <= g;
    endtask
    task automatic do_reti();
        @(posedge clock_i);
        reti_req <= 1'b1;
        @(posedge clock_i);
        reti_req <= 1'b0;
    endtask
    task automatic finish_test();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////////////
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    initial begin
        rst_b_i = 1'b0;
        {req, en, hi, gen, sleep, w0, alarm, reti_req, edge_sel, acc} = '0;
        void'($urandom(32'hff47ebce));
        // all raised, none selected high: lowest enabled polling index must win
        for (int i = 0; i < 13; i++) begin
            do_reset();
            en  <= (13'($urandom()) | (13'h1 << i)) & ~((13'h1 << i) - 13'h1);
            req <= '1;
            wait_vec(200);
            check("vec_addr", got, VEC_TABLE[i]);
            check("latency", 16'(n > int'(LAT_MIN_Q) && n <= int'(LAT_MAX_Q) + 1), 16'h1);
            check("push", 16'(push_v), 16'h1);
            check("push_pc", push_pc, pc_at);
            check("level", 16'(lvl), 16'((i == 0) ? LVL_PWR : LVL_LOW));
        end
        // global gate first, then an enable access held on keeps vectoring off
        do_reset(1'b0);
        en  <= '1;
        req <= '1;
        acc <= 1'b1;
        wait_vec(100);
        check("gated", got, 16'hffff);
        @(posedge clock_i);
        gen <= 1'b1;
        wait_vec(100);
        check("acc_hold", got, 16'hffff);
        @(posedge clock_i);
        acc <= 1'b0;
        wait_vec(200);
        check("after_acc", got, VEC_TABLE[SRC_PWR]);
        // nesting: high over low, same level refused, power over high, LIFO unwind
        do_reset();
        en <= '1;
        hi <= 13'h1100;
        req[6] <= 1'b1;
        wait_vec(200);
        pushed[0] = pc_at;
        check("low_vec", got, 16'h000b);
        @(posedge clock_i);
        req[8] <= 1'b1;
        wait_vec(200);
        pushed[1] = pc_at;
        check("high_vec", got, 16'h001b);
        @(posedge clock_i);
        req[12] <= 1'b1;
        wait_vec(100);
        check("same_lvl", got, 16'hffff);
        @(posedge clock_i);
        req[0] <= 1'b1;
        wait_vec(200);
        pushed[2] = pc_at;
        check("pwr_vec", got, 16'h0043);
        @(posedge clock_i);
        req <= '0;
        for (int k = 2; k >= 0; k--) begin
            do_reti();
            for (int t = 0; t < 60 && res_v !== 1'b1; t++) @(negedge clock_i);
            check("resume_pc", res_pc, pushed[k]);
        end
        // flag-driven and level-mode sources re-enter after return
        foreach (keep_src[j]) begin
            do_reset();
            en <= '1;
            req[keep_src[j]] <= 1'b1;
            wait_vec(200);
            do_reti();
            wait_vec(200);
            check("reenter", got, VEC_TABLE[keep_src[j]]);
        end
        do_reset();
        en <= '1;
        edge_sel <= 2'b01;
        req[5] <= 1'b1;
        wait_vec(200);
        check("edge_vec", got, 16'h0003);
        repeat (4) @(negedge clock_i);
        check("edge_flag", 16'(f0), 16'h0);
        do_reti();
        wait_vec(80);
        check("edge_once", got, 16'hffff);
        do_reset();
        en <= '1;
        alarm <= 1'b1;
        @(posedge clock_i);
        alarm <= 1'b0;
        wait_vec(80);
        check("rtc_cancel", got, 16'hffff);
        // latched pulses wait for their enables, then clear on entry only
        do_reset();
        req <= 13'h0210;
        @(posedge clock_i);
        req <= '0;
        repeat (20) @(posedge clock_i);
        en <= 13'h0210;
        wait_vec(200);
        check("temp_vec", got, 16'h0033);
        do_reti();
        wait_vec(200);
        check("serial_vec", got, 16'h003b);
        do_reti();
        wait_vec(80);
        check("latch_clr", got, 16'hffff);
        do_reset();
        en <= '1;
        sleep <= 1'b1;
        edge_sel <= 2'b01;
        req[5] <= 1'b1;
        w0 <= 1'b1;
        @(posedge clock_i);
        w0 <= 1'b0;
        repeat (3) @(negedge clock_i);
        check("sleep_flag", 16'(f0), 16'h0);
        @(posedge clock_i);
        sleep <= 1'b0;
        req[5] <= 1'b0;
        wait_vec(200);
        check("wake_vec", got, 16'h0003);
        do_reti();
        wait_vec(200);
        check("wake1_vec", got, VEC_TABLE[SRC_EXT1]);
        finish_test();
    end
endmodule // tb_priority_interrupt_controller
`default_nettype wire
